// File: rtl/sbrg_pkg.sv
// package: register map, field layout and reset values of the baud-rate generator
package sbrg_pkg;

    // register byte offsets
    localparam logic [7:0] BAUD_CTRL_OFS   = 8'h00;
    localparam logic [7:0] BAUD_RELOAD_OFS = 8'h04;
    localparam logic [7:0] FRAC_CTRL_OFS   = 8'h08;
    localparam logic [7:0] FRAC_STEP_OFS   = 8'h0c;
    localparam logic [7:0] FRAC_RESULT_OFS = 8'h10;
    localparam logic [7:0] BAUD_COUNT_OFS  = 8'h14;
    localparam logic [7:0] IRQ_STATUS_OFS  = 8'h18;
    localparam logic [7:0] IRQ_MASK_OFS    = 8'h1c;

    // baud_control_register fields
    localparam int BAUD_RUN_BIT  = 0;
    localparam int PRESCALE_LSB  = 1;
    localparam int PRESCALE_W    = 3;

    // frac_div_control fields
    localparam int FRAC_EN_BIT   = 0;
    localparam int FRAC_MODE_BIT = 1;

    // interrupt status / mask fields
    localparam int IRQ_OVF_BIT   = 0;
    localparam int IRQ_BAUD_BIT  = 1;
    localparam int IRQ_W         = 2;

    // reset values
    localparam logic [7:0]        BAUD_CTRL_RST   = 8'h00;
    localparam logic [7:0]        BAUD_RELOAD_RST = 8'h00;
    localparam logic [7:0]        FRAC_CTRL_RST   = 8'h00;
    localparam logic [7:0]        FRAC_STEP_RST   = 8'h00;
    localparam logic [IRQ_W-1:0]  IRQ_MASK_RST    = 2'h0;
    localparam logic [IRQ_W-1:0]  IRQ_STATUS_RST  = 2'h0;

    // frac_div_mode_select encodings
    localparam logic MODE_FRACTIONAL = 1'b0;
    localparam logic MODE_NORMAL     = 1'b1;

endpackage : sbrg_pkg

// File: rtl/sbrg_div_if.sv
// interface: control and tick lines between the top and the fractional divider
interface sbrg_div_if;
    logic       enable;
    logic       mode;
    logic [7:0] step;
    logic       in_tick;
    logic       out_tick;
    logic       overflow;
    logic [7:0] result;

    modport div (
        input  enable,
        input  mode,
        input  step,
        input  in_tick,
        output out_tick,
        output overflow,
        output result
    );

    modport ctl (
        output enable,
        output mode,
        output step,
        output in_tick,
        input  out_tick,
        input  overflow,
        input  result
    );
endinterface : sbrg_div_if

// File: rtl/sbrg_frac_div.sv
// fractional divider: step/256 accumulator or 8-bit up-counting auto-reload timer
module sbrg_frac_div (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // control and ticks
    sbrg_div_if.div   dif
);

    logic [7:0] acc;
    logic [7:0] next_acc;
    logic       out_tick;
    logic       next_out_tick;
    logic       overflow;
    logic       next_overflow;
    logic [8:0] sum;

    always_comb begin
        next_acc      = acc;
        next_out_tick = 1'b0;
        next_overflow = 1'b0;
        sum           = {1'b0, acc} + {1'b0, dif.step};
        if (!dif.enable) begin
            next_acc = 8'h00;
        end else if (dif.in_tick) begin
            if (dif.mode == sbrg_pkg::MODE_FRACTIONAL) begin
                next_acc      = sum[7:0];
                next_out_tick = sum[8];
            end else if (acc == 8'hff) begin
                // overflow reloads from step: period 256 - step
                next_acc      = dif.step;
                next_out_tick = 1'b1;
                next_overflow = 1'b1;
            end else begin
                next_acc = acc + 8'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            acc      <= 8'h00;
            out_tick <= 1'b0;
            overflow <= 1'b0;
        end else begin
            acc      <= next_acc;
            out_tick <= next_out_tick;
            overflow <= next_overflow;
        end
    end

    assign dif.out_tick = out_tick;
    assign dif.overflow = overflow;
    assign dif.result   = acc;

endmodule : sbrg_frac_div

// File: rtl/sbrg_top.sv
// top: baud-rate generator with prescaler, fractional divider, baud timer, APB registers
//////////////////////////////////////////////////////////////////////////////////////////
// How it works
// - baud timer underflow reloads, emits one pulse
// - divider enable selects divider or prescaler tick
// - normal divider mode halts timer, ignores run
// - prescaler divides by two to prescale_select
// - fractional divider scales input by step/256
// - one pulse per reload-plus-one input ticks
// - normal mode counts up, overflow flags, interrupts
//////////////////////////////////////////////////////////////////////////////////////////
//
// The register addresses and the APB interface to the registers were left to the implementer.
module sbrg_top #(
    parameter int PRESCALE_W = sbrg_pkg::PRESCALE_W
) (
    // clock and reset
    input  wire logic        I_CLK,
    input  wire logic        I_RST,
    // apb slave
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [7:0]  I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic      [31:0] O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    // serial channel and divider clocks
    output logic             O_BAUD_TICK,
    output logic             O_DIV_TICK,
    // interrupt
    output logic             O_IRQ
);

    localparam int PRE_MAX = (1 << ((1 << PRESCALE_W) - 1));
    localparam int PRE_CW  = (1 << PRESCALE_W) - 1;

    //////////////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic is_mapped(input logic [7:0] addr);
        case (addr)
            sbrg_pkg::BAUD_CTRL_OFS,
            sbrg_pkg::BAUD_RELOAD_OFS,
            sbrg_pkg::FRAC_CTRL_OFS,
            sbrg_pkg::FRAC_STEP_OFS,
            sbrg_pkg::FRAC_RESULT_OFS,
            sbrg_pkg::BAUD_COUNT_OFS,
            sbrg_pkg::IRQ_STATUS_OFS,
            sbrg_pkg::IRQ_MASK_OFS: is_mapped = 1'b1;
            default:                is_mapped = 1'b0;
        endcase
    endfunction : is_mapped

    // low-bit mask selecting a divide by 2**sel
    function automatic logic [PRE_CW-1:0] pre_mask(input logic [PRESCALE_W-1:0] sel);
        logic [PRE_CW:0] one_hot;
        one_hot  = '0;
        one_hot[sel] = 1'b1;
        pre_mask = PRE_CW'(one_hot - 1'b1);
    endfunction : pre_mask

    //////////////////////////////////////////////////////////////////////////////////////
    // registers

    logic [7:0]              baud_control_register;
    logic [7:0]              baud_reload_register;
    logic [7:0]              frac_div_control;
    logic [7:0]              frac_step_register;
    logic [sbrg_pkg::IRQ_W-1:0] irq_status;
    logic [sbrg_pkg::IRQ_W-1:0] irq_mask;
    logic [7:0]              next_baud_control_register;
    logic [7:0]              next_baud_reload_register;
    logic [7:0]              next_frac_div_control;
    logic [7:0]              next_frac_step_register;
    logic [sbrg_pkg::IRQ_W-1:0] next_irq_status;
    logic [sbrg_pkg::IRQ_W-1:0] next_irq_mask;

    logic                    pready;
    logic                    pslverr;
    logic [31:0]             prdata;
    logic                    next_pready;
    logic                    next_pslverr;
    logic [31:0]             next_prdata;
    logic                    irq;
    logic                    next_irq;

    logic                    wr_en;
    logic [sbrg_pkg::IRQ_W-1:0] irq_events;

    // datapath state
    logic [PRE_CW-1:0]       pre_cnt;
    logic [PRE_CW-1:0]       next_pre_cnt;
    logic                    pre_tick;
    logic                    next_pre_tick;
    logic [7:0]              baud_cnt;
    logic [7:0]              next_baud_cnt;
    logic                    baud_tick;
    logic                    next_baud_tick;
    logic                    div_tick;
    logic                    next_div_tick;

    logic                    baud_timer_run;
    logic [PRESCALE_W-1:0]   baud_prescale_select;
    logic                    frac_div_enable;
    logic                    frac_div_mode_select;
    logic                    timer_active;
    logic                    timer_clk_tick;
    logic                    divider_output_clock;

    sbrg_div_if dif ();

    assign baud_timer_run       = baud_control_register[sbrg_pkg::BAUD_RUN_BIT];
    assign baud_prescale_select = baud_control_register[sbrg_pkg::PRESCALE_LSB +: PRESCALE_W];
    assign frac_div_enable      = frac_div_control[sbrg_pkg::FRAC_EN_BIT];
    assign frac_div_mode_select = frac_div_control[sbrg_pkg::FRAC_MODE_BIT];

    // the run bit only counts while the divider is not an independent timer
    assign timer_active = baud_timer_run &&
                          !(frac_div_enable &&
                            frac_div_mode_select == sbrg_pkg::MODE_NORMAL);

    // the timer takes the divider pulse one cycle ahead of O_DIV_TICK
    assign divider_output_clock = dif.out_tick;
    assign timer_clk_tick = frac_div_enable ? divider_output_clock : pre_tick;

    assign dif.enable  = frac_div_enable;
    assign dif.mode    = frac_div_mode_select;
    assign dif.step    = frac_step_register;
    assign dif.in_tick = pre_tick;

    sbrg_frac_div u_frac_div (
        .clk (I_CLK),
        .rst (I_RST),
        .dif (dif.div)
    );

    //////////////////////////////////////////////////////////////////////////////////////
    // prescaler: free-running counter, tick when the selected low bits are all ones

    // free-running: a new select does not restart the phase
    always_comb begin
        logic [PRE_CW-1:0] m;
        m             = pre_mask(baud_prescale_select);
        next_pre_cnt  = pre_cnt + 1'b1;
        next_pre_tick = ((pre_cnt & m) == m);
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            pre_cnt  <= '0;
            pre_tick <= 1'b0;
        end else begin
            pre_cnt  <= next_pre_cnt;
            pre_tick <= next_pre_tick;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // baud timer: count down, reload on underflow

    always_comb begin
        next_baud_cnt  = baud_cnt;
        next_baud_tick = 1'b0;
        next_div_tick  = divider_output_clock;
        if (!timer_active) begin
            // stopped timer restarts from the full reload period
            next_baud_cnt = baud_reload_register;
        end else if (timer_clk_tick) begin
            // reload read live: a new value applies at the next underflow
            if (baud_cnt == 8'h00) begin
                next_baud_cnt  = baud_reload_register;
                next_baud_tick = 1'b1;
            end else begin
                next_baud_cnt = baud_cnt - 8'h01;
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            baud_cnt  <= 8'h00;
            baud_tick <= 1'b0;
            div_tick  <= 1'b0;
        end else begin
            baud_cnt  <= next_baud_cnt;
            baud_tick <= next_baud_tick;
            div_tick  <= next_div_tick;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // apb slave: one wait state, write and read take effect with pready

    assign wr_en = I_PSEL && I_PENABLE && pready && I_PWRITE && is_mapped(I_PADDR);

    // interrupt sources: divider overflow and baud pulse
    assign irq_events[sbrg_pkg::IRQ_OVF_BIT]  = dif.overflow;
    assign irq_events[sbrg_pkg::IRQ_BAUD_BIT] = baud_tick;

    always_comb begin
        next_baud_control_register = baud_control_register;
        next_baud_reload_register  = baud_reload_register;
        next_frac_div_control      = frac_div_control;
        next_frac_step_register    = frac_step_register;
        next_irq_mask              = irq_mask;
        if (wr_en) begin
            case (I_PADDR)
                sbrg_pkg::BAUD_CTRL_OFS:   next_baud_control_register = I_PWDATA[7:0];
                sbrg_pkg::BAUD_RELOAD_OFS: next_baud_reload_register  = I_PWDATA[7:0];
                sbrg_pkg::FRAC_CTRL_OFS:   next_frac_div_control      = {6'h00, I_PWDATA[1:0]};
                sbrg_pkg::FRAC_STEP_OFS:   next_frac_step_register    = I_PWDATA[7:0];
                sbrg_pkg::IRQ_MASK_OFS:    next_irq_mask = I_PWDATA[sbrg_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // the read word is captured on the edge that raises pready
    always_comb begin
        next_pready  = I_PSEL && I_PENABLE && !pready;
        next_pslverr = 1'b0;
        next_prdata  = prdata;
        if (next_pready) begin
            next_pslverr = !is_mapped(I_PADDR);
            next_prdata  = 32'h0000_0000;
            if (!I_PWRITE) begin
                case (I_PADDR)
                    sbrg_pkg::BAUD_CTRL_OFS:   next_prdata[7:0] = baud_control_register;
                    sbrg_pkg::BAUD_RELOAD_OFS: next_prdata[7:0] = baud_reload_register;
                    sbrg_pkg::FRAC_CTRL_OFS:   next_prdata[7:0] = frac_div_control;
                    sbrg_pkg::FRAC_STEP_OFS:   next_prdata[7:0] = frac_step_register;
                    sbrg_pkg::FRAC_RESULT_OFS: next_prdata[7:0] = dif.result;
                    sbrg_pkg::BAUD_COUNT_OFS:  next_prdata[7:0] = baud_cnt;
                    sbrg_pkg::IRQ_STATUS_OFS:
                        next_prdata[sbrg_pkg::IRQ_W-1:0] = irq_status;
                    sbrg_pkg::IRQ_MASK_OFS:
                        next_prdata[sbrg_pkg::IRQ_W-1:0] = irq_mask;
                    default: next_prdata = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            baud_control_register <= sbrg_pkg::BAUD_CTRL_RST;
            baud_reload_register  <= sbrg_pkg::BAUD_RELOAD_RST;
            frac_div_control      <= sbrg_pkg::FRAC_CTRL_RST;
            frac_step_register    <= sbrg_pkg::FRAC_STEP_RST;
            irq_mask              <= sbrg_pkg::IRQ_MASK_RST;
            pready                <= 1'b0;
            pslverr               <= 1'b0;
            prdata                <= 32'h0000_0000;
        end else begin
            baud_control_register <= next_baud_control_register;
            baud_reload_register  <= next_baud_reload_register;
            frac_div_control      <= next_frac_div_control;
            frac_step_register    <= next_frac_step_register;
            irq_mask              <= next_irq_mask;
            pready                <= next_pready;
            pslverr               <= next_pslverr;
            prdata                <= next_prdata;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // interrupts: sticky status, write one to clear, level output

    always_comb begin
        next_irq_status = irq_status;
        if (wr_en && I_PADDR == sbrg_pkg::IRQ_STATUS_OFS) begin
            next_irq_status = irq_status & ~I_PWDATA[sbrg_pkg::IRQ_W-1:0];
        end
        // an event in the clearing cycle survives the clear
        next_irq_status = next_irq_status | irq_events;
        // unmasking a bit already set raises the line one cycle later
        next_irq        = |(next_irq_status & irq_mask);
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            irq_status <= sbrg_pkg::IRQ_STATUS_RST;
            irq        <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            irq        <= next_irq;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign O_PRDATA    = prdata;
    assign O_PREADY    = pready;
    assign O_PSLVERR   = pslverr;
    assign O_BAUD_TICK = baud_tick;
    assign O_DIV_TICK  = div_tick;
    assign O_IRQ       = irq;

endmodule : sbrg_top

// File: sim/sbrg_top_properties.sv
// checker: port-level properties of the baud-rate generator
module sbrg_top_properties #(
    parameter int PRESCALE_W = 3
) (
    // clock, reset and bus
    input wire logic        I_CLK,
    input wire logic        I_RST,
    input wire logic        I_PSEL,
    input wire logic        I_PENABLE,
    input wire logic        I_PWRITE,
    input wire logic [7:0]  I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic [31:0] O_PRDATA,
    input wire logic        O_PREADY,
    input wire logic        O_PSLVERR,
    // ticks and interrupt
    input wire logic        O_BAUD_TICK,
    input wire logic        O_DIV_TICK,
    input wire logic        O_IRQ
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    ////////////////////////////////////////////////////////////////
    // shadow of the written setup, so properties know the mode
    logic       wr;
    logic [1:0] fctl;
    logic [7:0] step;
    logic [1:0] mask;
    logic [3:0] quiet;
    assign wr = I_PSEL && I_PENABLE && I_PWRITE && O_PREADY;
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            fctl  <= 2'h0;
            step  <= 8'h00;
            mask  <= 2'h0;
            quiet <= 4'h0;
        end else begin
            if (wr && I_PADDR == sbrg_pkg::FRAC_CTRL_OFS) fctl <= I_PWDATA[1:0];
            if (wr && I_PADDR == sbrg_pkg::FRAC_STEP_OFS) step <= I_PWDATA[7:0];
            if (wr && I_PADDR == sbrg_pkg::IRQ_MASK_OFS) mask <= I_PWDATA[1:0];
            quiet <= wr ? 4'h0 : (quiet == 4'hf ? quiet : quiet + 4'h1);
        end
    end
    ////////////////////////////////////////////////////////////////
    property p_ready_pulse;
        $rose(I_PENABLE) && I_PSEL |=> O_PREADY ##1 !O_PREADY;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready not one pulse");
    property p_unmapped;
        O_PREADY && I_PADDR > 8'h1c |-> O_PSLVERR && O_PRDATA == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_mapped;
        O_PREADY && I_PADDR <= 8'h1c && I_PADDR[1:0] == 2'h0 |-> !O_PSLVERR;
    endproperty
    a_mapped: assert property (p_mapped) else $error("mapped access refused");
    property p_high_zero;
        O_PREADY |-> O_PRDATA[31:8] == 24'h0;
    endproperty
    a_high_zero: assert property (p_high_zero) else $error("upper read bits set");
    property p_normal_halt;
        fctl == 2'h3 && quiet >= 4'h4 |-> !O_BAUD_TICK;
    endproperty
    a_normal_halt: assert property (p_normal_halt) else $error("baud tick in normal mode");
    property p_step0_nodiv;
        fctl == 2'h1 && step == 8'h00 && quiet >= 4'h4 |-> !O_DIV_TICK;
    endproperty
    a_step0_nodiv: assert property (p_step0_nodiv) else $error("carry with zero step");
    property p_step0_nobaud;
        fctl == 2'h1 && step == 8'h00 && quiet >= 4'h4 |-> !O_BAUD_TICK;
    endproperty
    a_step0_nobaud: assert property (p_step0_nobaud) else $error("baud without source");
    property p_mask_irq;
        mask == 2'h0 && quiet >= 4'h3 |-> !O_IRQ;
    endproperty
    a_mask_irq: assert property (p_mask_irq) else $error("irq while all masked");
    c_baud: cover property (O_BAUD_TICK);
    c_div: cover property (O_DIV_TICK);
    c_irq: cover property (O_IRQ);
endmodule : sbrg_top_properties

bind sbrg_top sbrg_top_properties #(.PRESCALE_W(PRESCALE_W)) i_props (.I_CLK(I_CLK),
    .I_RST(I_RST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE),
    .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
    .O_PSLVERR(O_PSLVERR), .O_BAUD_TICK(O_BAUD_TICK), .O_DIV_TICK(O_DIV_TICK), .O_IRQ(O_IRQ));

// File: sim/tb_sbrg_top.sv
// testbench: register, baud, divider and interrupt scenarios
module tb_sbrg_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        I_CLK;
    logic        I_RST;
    logic        I_PSEL;
    logic        I_PENABLE;
    logic        I_PWRITE;
    logic [7:0]  I_PADDR;
    logic [31:0] I_PWDATA;
    logic [31:0] O_PRDATA;
    logic        O_PREADY;
    logic        O_PSLVERR;
    logic        O_BAUD_TICK;
    logic        O_DIV_TICK;
    logic        O_IRQ;
    logic [31:0] rd;
    logic        err;
    int          g;
    int          n_mismatch = 0;
    int          checks_done = 0;

    sbrg_top #(.PRESCALE_W(3)) i_sbrg_top (.I_CLK(I_CLK), .I_RST(I_RST), .I_PSEL(I_PSEL),
        .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
        .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
        .O_BAUD_TICK(O_BAUD_TICK), .O_DIV_TICK(O_DIV_TICK), .O_IRQ(O_IRQ));
    ////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // read values right after the edge: they are what the edge sampled
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge I_CLK);
        I_PSEL    <= 1'b1;
        I_PENABLE <= 1'b0;
        I_PADDR   <= a;
        I_PWRITE  <= w;
        I_PWDATA  <= d;
        @(posedge I_CLK);
        I_PENABLE <= 1'b1;
        k = 0;
        do begin
            @(posedge I_CLK);
            k++;
        end while (O_PREADY !== 1'b1 && k < 64);
        rd  = O_PRDATA;
        err = O_PSLVERR;
        if (O_PREADY !== 1'b1) n_mismatch++;
        I_PSEL    <= 1'b0;
        I_PENABLE <= 1'b0;
    endtask : apb
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0);
        chk(rd, e);
    endtask : rchk
    // waits for one tick, then counts cycles to the next one
    task automatic gap(input logic dv, output int n);
        int k;
        k = 0;
        do begin
            @(negedge I_CLK);
            k++;
        end while ((dv ? O_DIV_TICK : O_BAUD_TICK) !== 1'b1 && k < 4000);
        n = 0;
        do begin
            @(negedge I_CLK);
            n++;
        end while ((dv ? O_DIV_TICK : O_BAUD_TICK) !== 1'b1 && n < 4000);
    endtask : gap
    task automatic count(input logic dv, input int cyc, output int n);
        n = 0;
        repeat (cyc) begin
            @(negedge I_CLK);
            if ((dv ? O_DIV_TICK : O_BAUD_TICK) === 1'b1) n++;
        end
    endtask : count
    ////////////////////////////////////////////////////////////////
    task automatic t_regs();
        for (int i = 0; i < 8; i++) rchk(8'(4 * i), 32'h0);
        apb(sbrg_pkg::BAUD_RELOAD_OFS, 1'b1, 32'h5a);
        rchk(sbrg_pkg::BAUD_RELOAD_OFS, 32'h5a);
        rchk(sbrg_pkg::BAUD_COUNT_OFS, 32'h5a);
        apb(sbrg_pkg::FRAC_STEP_OFS, 1'b1, 32'ha5);
        rchk(sbrg_pkg::FRAC_STEP_OFS, 32'ha5);
        apb(8'h20, 1'b1, 32'hff);
        chk(32'(err), 32'h1);
        rchk(8'h20, 32'h0);
    endtask : t_regs
    task automatic t_baud();
        int sel[3] = '{0, 3, 1};
        int rel[3] = '{0, 2, 255};
        apb(sbrg_pkg::FRAC_CTRL_OFS, 1'b1, 32'h0);
        for (int i = 0; i < 3; i++) begin
            apb(sbrg_pkg::BAUD_RELOAD_OFS, 1'b1, 32'(rel[i]));
            apb(sbrg_pkg::BAUD_CTRL_OFS, 1'b1, 32'((sel[i] << 1) | 1));
            gap(1'b0, g);
            gap(1'b0, g);
            chk(32'(g), 32'((1 << sel[i]) * (rel[i] + 1)));
        end
        apb(sbrg_pkg::BAUD_CTRL_OFS, 1'b1, 32'h0);
        count(1'b0, 64, g);
        chk(32'(g), 32'h0);
    endtask : t_baud
    task automatic t_frac();
        apb(sbrg_pkg::BAUD_RELOAD_OFS, 1'b1, 32'h1);
        apb(sbrg_pkg::BAUD_CTRL_OFS, 1'b1, 32'h1);
        apb(sbrg_pkg::FRAC_STEP_OFS, 1'b1, 32'h80);
        apb(sbrg_pkg::FRAC_CTRL_OFS, 1'b1, 32'h1);
        gap(1'b1, g);
        chk(32'(g), 32'h2);
        gap(1'b0, g);
        gap(1'b0, g);
        chk(32'(g), 32'h4);
        apb(sbrg_pkg::FRAC_STEP_OFS, 1'b1, 32'h40);
        gap(1'b1, g);
        gap(1'b1, g);
        chk(32'(g), 32'h4);
        apb(sbrg_pkg::FRAC_STEP_OFS, 1'b1, 32'h0);
        // a carry already in flight may still show
        repeat (4) @(negedge I_CLK);
        count(1'b1, 50, g);
        chk(32'(g), 32'h0);
    endtask : t_frac
    task automatic t_normal();
        apb(sbrg_pkg::FRAC_STEP_OFS, 1'b1, 32'hfc);
        apb(sbrg_pkg::FRAC_CTRL_OFS, 1'b1, 32'h3);
        // first ticks may be carries left over from fractional mode
        gap(1'b1, g);
        gap(1'b1, g);
        chk(32'(g), 32'h4);
        count(1'b0, 100, g);
        chk(32'(g), 32'h0);
        chk(32'(O_IRQ), 32'h0);
        apb(sbrg_pkg::IRQ_MASK_OFS, 1'b1, 32'h1);
        repeat (8) @(negedge I_CLK);
        chk(32'(O_IRQ), 32'h1);
        apb(sbrg_pkg::IRQ_STATUS_OFS, 1'b0, 32'h0);
        chk(rd & 32'h1, 32'h1);
        // stop both sources first, or the flags re-arm at once
        apb(sbrg_pkg::BAUD_CTRL_OFS, 1'b1, 32'h0);
        apb(sbrg_pkg::FRAC_CTRL_OFS, 1'b1, 32'h0);
        apb(sbrg_pkg::IRQ_STATUS_OFS, 1'b1, 32'h3);
        rchk(sbrg_pkg::IRQ_STATUS_OFS, 32'h0);
        repeat (3) @(negedge I_CLK);
        chk(32'(O_IRQ), 32'h0);
    endtask : t_normal
    ////////////////////////////////////////////////////////////////
    initial begin
        I_CLK = 1'b0;
        forever #20 I_CLK = ~I_CLK;
    end
    initial begin
        #2000000;
        n_mismatch++;
        close_out();
    end
    initial begin
        I_RST     = 1'b1;
        I_PSEL    = 1'b0;
        I_PENABLE = 1'b0;
        I_PWRITE  = 1'b0;
        I_PADDR   = 8'h00;
        I_PWDATA  = 32'h0;
        repeat (16) @(posedge I_CLK);
        I_RST <= 1'b0;
        t_regs();
        t_baud();
        t_frac();
        t_normal();
        close_out();
    end
endmodule : tb_sbrg_top
